// ==== verilog/ufs_pkg.sv ====
package ufs_pkg;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [31:0] UFS_QCW_ADDR   = 32'h500011e0;
	localparam logic [31:0] UFS_SFE_ADDR   = 32'h50001198;
	localparam logic [31:0] UFS_SRT_ADDR   = 32'h5000119c;
	localparam logic [31:0] UFS_STET_ADDR  = 32'h500011a0;
	localparam logic [31:0] UFS_HALT_ADDR  = 32'h500011a4;
	localparam logic [31:0] UFS_PARM_ADDR  = 32'h500011f4;

	// ----------------------------------------------------------------
	// Control word field positions
	// ----------------------------------------------------------------
	localparam int UFS_QCW_EN_BIT      = 0;
	localparam int UFS_QCW_RXCLR_BIT   = 1;
	localparam int UFS_QCW_TXCLR_BIT   = 2;
	localparam int UFS_QCW_DMA_BIT     = 3;
	localparam int UFS_QCW_TXTRIG_LSB  = 4;
	localparam int UFS_QCW_RXTRIG_LSB  = 6;
	localparam int UFS_SHADOW_BIT      = 0;
	localparam int UFS_REG_WIDTH       = 16;

	// ----------------------------------------------------------------
	// Reset values and bus answers
	// ----------------------------------------------------------------
	localparam logic [1:0]  UFS_TRIG_RESET = 2'h0;
	localparam logic        UFS_BIT_RESET  = 1'h0;
	localparam logic [15:0] UFS_PARM_RESET = 16'h0000;
	localparam logic [1:0]  UFS_RESP_OKAY  = 2'h0;
	localparam logic [1:0]  UFS_RESP_DEC   = 2'h3;

	// ----------------------------------------------------------------
	// Trigger encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] UFS_TRIG_0 = 2'h0;
	localparam logic [1:0] UFS_TRIG_1 = 2'h1;
	localparam logic [1:0] UFS_TRIG_2 = 2'h2;
	localparam logic [1:0] UFS_TRIG_3 = 2'h3;

	typedef struct packed {
		logic [1:0] rx_trig;
		logic [1:0] tx_trig;
		logic       dma_mode;
		logic       fifo_en;
	} ufs_qcw_s;

	typedef struct packed {
		logic [31:0] data;
		logic [1:0]  resp;
	} ufs_rd_s;

endpackage

// ==== verilog/ufs_shadow_ctrl.sv ====
// Function
// - Enable shadow write changes only enable field
// - Enable falling resets both queue controllers
// - Receive trigger shadow changes only that field
// - Receive trigger picks receive data interrupt level
// - DMA mode one: receive request follows trigger
// - Transmit trigger shadow changes only that field
// - Transmit trigger picks holding-empty interrupt level
// - Halt bit with queues enabled stops transmit
// - Halt bit ignored when queues disabled
// - Parameter word read-only, zero after reset
// - DMA mode bit selects request signalling mode
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module ufs_shadow_ctrl
	import ufs_pkg::*;
#(
	parameter int          QUEUE_DEPTH = 16,
	parameter logic [15:0] PARM_VALUE  = UFS_PARM_RESET
)
(
	input  wire logic                          sys_clk,
	input  wire logic                          reset,
	input  wire logic [31:0]                   s_axi_awaddr,
	input  wire logic [2:0]                    s_axi_awprot,
	input  wire logic                          s_axi_awvalid,
	output var  logic                          s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output var  logic                          s_axi_wready,
	output var  logic [1:0]                    s_axi_bresp,
	output var  logic                          s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [31:0]                   s_axi_araddr,
	input  wire logic [2:0]                    s_axi_arprot,
	input  wire logic                          s_axi_arvalid,
	output var  logic                          s_axi_arready,
	output var  logic [31:0]                   s_axi_rdata,
	output var  logic [1:0]                    s_axi_rresp,
	output var  logic                          s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	input  wire logic [$clog2(QUEUE_DEPTH):0]  rx_level,
	input  wire logic [$clog2(QUEUE_DEPTH):0]  tx_level,
	input  wire logic                          tx_empty_prog,
	output var  logic                          queue_enable,
	output var  logic                          receive_queue_reset,
	output var  logic                          transmit_queue_reset,
	output var  logic                          rx_data_avail_irq,
	output var  logic                          tx_holding_empty_irq,
	output var  logic                          rx_dma_req_n,
	output var  logic                          tx_dma_req_n,
	output var  logic                          transmit_halt
);

	localparam int LW = $clog2(QUEUE_DEPTH) + 1;
	localparam logic [LW-1:0] LVL_ONE  = LW'(1);
	localparam logic [LW-1:0] LVL_TWO  = LW'(2);
	localparam logic [LW-1:0] LVL_HALF = LW'(QUEUE_DEPTH / 2);
	localparam logic [LW-1:0] LVL_NEAR = LW'(QUEUE_DEPTH - 2);
	localparam logic [LW-1:0] LVL_ZERO = LW'(0);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic logic [5:0] ufs_decode(input logic [31:0] addr);
		logic [5:0] hit;
		hit    = 6'h00;
		hit[0] = (addr == UFS_QCW_ADDR);
		hit[1] = (addr == UFS_SFE_ADDR);
		hit[2] = (addr == UFS_SRT_ADDR);
		hit[3] = (addr == UFS_STET_ADDR);
		hit[4] = (addr == UFS_HALT_ADDR);
		hit[5] = (addr == UFS_PARM_ADDR);
		return hit;
	endfunction

	ufs_qcw_s    qcw_reg;
	ufs_qcw_s    qcw_next;
	logic        halt_reg;
	logic        halt_next;
	logic        rxclr_pulse;
	logic        txclr_pulse;

	// ----------------------------------------------------------------
	// Write channel
	// ----------------------------------------------------------------
	logic        awready_reg;
	logic        wready_reg;
	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	logic        aw_got_reg;
	logic        w_got_reg;
	logic [31:0] waddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;

	wire logic aw_take  = s_axi_awvalid & awready_reg;
	wire logic w_take   = s_axi_wvalid & wready_reg;
	wire logic do_write = aw_got_reg & w_got_reg & ~bvalid_reg;
	wire logic aw_got_next = (aw_got_reg | aw_take) & ~do_write;
	wire logic w_got_next  = (w_got_reg | w_take) & ~do_write;
	wire logic bvalid_next = do_write | (bvalid_reg & ~s_axi_bready);
	wire logic [5:0] whit  = ufs_decode(waddr_reg);
	wire logic lane0       = wstrb_reg[0];
	wire logic [1:0] bresp_next = (whit == 6'h00) ? UFS_RESP_DEC
	                                              : UFS_RESP_OKAY;

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			awready_reg <= 1'h0;
			wready_reg  <= 1'h0;
			bvalid_reg  <= 1'h0;
			bresp_reg   <= UFS_RESP_OKAY;
			aw_got_reg  <= 1'h0;
			w_got_reg   <= 1'h0;
			waddr_reg   <= 32'h00000000;
			wdata_reg   <= 32'h00000000;
			wstrb_reg   <= 4'h0;
		end
		else
		begin
			// One write at a time: hold off new halves until answered
			awready_reg <= ~aw_got_next & ~bvalid_next;
			wready_reg  <= ~w_got_next & ~bvalid_next;
			bvalid_reg  <= bvalid_next;
			aw_got_reg  <= aw_got_next;
			w_got_reg   <= w_got_next;
			if (do_write)
				bresp_reg <= bresp_next;
			if (aw_take)
				waddr_reg <= s_axi_awaddr;
			if (w_take)
			begin
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
		end
	end

	// ----------------------------------------------------------------
	// Control storage
	// ----------------------------------------------------------------
	// Every field lives once; shadows are only alternate write paths
	wire logic wr_lane = do_write & lane0;
	wire logic wr_qcw  = wr_lane & whit[0];
	wire logic wr_sfe  = wr_lane & whit[1];
	wire logic wr_srt  = wr_lane & whit[2];
	wire logic wr_stet = wr_lane & whit[3];
	wire logic wr_halt = wr_lane & whit[4];

	always_comb
	begin
		qcw_next  = qcw_reg;
		halt_next = halt_reg;
		if (wr_qcw)
		begin
			qcw_next.fifo_en  = wdata_reg[UFS_QCW_EN_BIT];
			qcw_next.dma_mode = wdata_reg[UFS_QCW_DMA_BIT];
			qcw_next.tx_trig  = wdata_reg[UFS_QCW_TXTRIG_LSB +: 2];
			qcw_next.rx_trig  = wdata_reg[UFS_QCW_RXTRIG_LSB +: 2];
		end
		if (wr_sfe)
			qcw_next.fifo_en = wdata_reg[UFS_SHADOW_BIT];
		if (wr_srt)
			qcw_next.rx_trig = wdata_reg[1:0];
		if (wr_stet)
			qcw_next.tx_trig = wdata_reg[1:0];
		if (wr_halt)
			halt_next = wdata_reg[UFS_SHADOW_BIT];
	end

	// ----------------------------------------------------------------
	// Queue controller clears
	// ----------------------------------------------------------------
	// Controllers clear on enable falling, or on the clear bits
	wire logic en_fall   = qcw_reg.fifo_en & ~qcw_next.fifo_en;
	assign rxclr_pulse   = en_fall | (wr_qcw & wdata_reg[UFS_QCW_RXCLR_BIT]);
	assign txclr_pulse   = en_fall | (wr_qcw & wdata_reg[UFS_QCW_TXCLR_BIT]);

	// ----------------------------------------------------------------
	// Threshold logic
	// ----------------------------------------------------------------
	logic rx_at_trig;
	logic tx_at_trig;

	always_comb
	begin
		case (qcw_reg.rx_trig)
			UFS_TRIG_0: rx_at_trig = (rx_level >= LVL_ONE);
			UFS_TRIG_1: rx_at_trig = (rx_level >= LVL_HALF);
			UFS_TRIG_2: rx_at_trig = (rx_level >= LVL_HALF);
			UFS_TRIG_3: rx_at_trig = (rx_level >= LVL_NEAR);
			default:    rx_at_trig = 1'h0;
		endcase
	end

	always_comb
	begin
		case (qcw_reg.tx_trig)
			UFS_TRIG_0: tx_at_trig = (tx_level == LVL_ZERO);
			UFS_TRIG_1: tx_at_trig = (tx_level <= LVL_TWO);
			UFS_TRIG_2: tx_at_trig = (tx_level <= LVL_HALF);
			// Undefined code treated as half full, the safest deepest
			UFS_TRIG_3: tx_at_trig = (tx_level <= LVL_HALF);
			default:    tx_at_trig = 1'h0;
		endcase
	end

	// ----------------------------------------------------------------
	// Interrupt outputs
	// ----------------------------------------------------------------
	wire logic rx_any   = (rx_level != LVL_ZERO);
	wire logic tx_empty = (tx_level == LVL_ZERO);
	// Without queues the trigger fields mean nothing
	wire logic rx_irq_next = qcw_reg.fifo_en ? rx_at_trig : rx_any;
	wire logic tx_irq_next = (qcw_reg.fifo_en & tx_empty_prog)
	                         ? tx_at_trig : tx_empty;
	// ----------------------------------------------------------------
	// Request and halt outputs
	// ----------------------------------------------------------------
	// Mode 0 asks per character, mode 1 waits for the threshold
	wire logic rx_dma_next = (qcw_reg.dma_mode & qcw_reg.fifo_en)
	                         ? rx_at_trig : rx_any;
	wire logic tx_dma_next = (qcw_reg.dma_mode & qcw_reg.fifo_en)
	                         ? tx_at_trig : tx_empty;
	wire logic halt_eff    = halt_reg & qcw_reg.fifo_en;

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			qcw_reg              <= '{UFS_TRIG_RESET, UFS_TRIG_RESET,
			                          UFS_BIT_RESET, UFS_BIT_RESET};
			halt_reg             <= UFS_BIT_RESET;
			queue_enable         <= 1'h0;
			receive_queue_reset  <= 1'h0;
			transmit_queue_reset <= 1'h0;
			rx_data_avail_irq    <= 1'h0;
			tx_holding_empty_irq <= 1'h0;
			rx_dma_req_n         <= 1'h1;
			tx_dma_req_n         <= 1'h1;
			transmit_halt        <= 1'h0;
		end
		else
		begin
			qcw_reg              <= qcw_next;
			halt_reg             <= halt_next;
			queue_enable         <= qcw_next.fifo_en;
			receive_queue_reset  <= rxclr_pulse;
			transmit_queue_reset <= txclr_pulse;
			rx_data_avail_irq    <= rx_irq_next;
			tx_holding_empty_irq <= tx_irq_next;
			rx_dma_req_n         <= ~rx_dma_next;
			tx_dma_req_n         <= ~tx_dma_next;
			transmit_halt        <= halt_eff;
		end
	end

	// ----------------------------------------------------------------
	// Read channel with two-entry answer buffer
	// ----------------------------------------------------------------
	// Two entries so a held rready never drops an answer
	logic    arready_reg;
	ufs_rd_s head_reg;
	ufs_rd_s tail_reg;
	logic    head_v_reg;
	logic    tail_v_reg;
	ufs_rd_s rd_item;

	wire logic       ar_take = s_axi_arvalid & arready_reg;
	wire logic [5:0] rhit    = ufs_decode(s_axi_araddr);
	wire logic       pop     = head_v_reg & s_axi_rready;

	// ----------------------------------------------------------------
	// Read data selection
	// ----------------------------------------------------------------

	always_comb
	begin
		rd_item.data = 32'h00000000;
		rd_item.resp = UFS_RESP_OKAY;
		// Control word itself is write-only and reads zero
		if (rhit[1])
			rd_item.data[0] = qcw_reg.fifo_en;
		else if (rhit[2])
			rd_item.data[1:0] = qcw_reg.rx_trig;
		else if (rhit[3])
			rd_item.data[1:0] = qcw_reg.tx_trig;
		else if (rhit[4])
			rd_item.data[0] = halt_reg;
		else if (rhit[5])
			rd_item.data[UFS_REG_WIDTH-1:0] = PARM_VALUE;
		else if (rhit == 6'h00)
			rd_item.resp = UFS_RESP_DEC;
	end

	wire logic head_free   = ~head_v_reg | pop;
	wire logic to_head     = ar_take & head_free & ~tail_v_reg;
	wire logic to_tail     = ar_take & ~to_head;
	wire logic head_v_next = (head_v_reg & ~pop) | tail_v_reg | to_head;
	wire logic tail_v_next = (tail_v_reg & ~head_free) | to_tail;

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			arready_reg <= 1'h0;
			head_v_reg  <= 1'h0;
			tail_v_reg  <= 1'h0;
			head_reg    <= '{32'h00000000, UFS_RESP_OKAY};
			tail_reg    <= '{32'h00000000, UFS_RESP_OKAY};
		end
		else
		begin
			arready_reg <= ~tail_v_next;
			head_v_reg  <= head_v_next;
			tail_v_reg  <= tail_v_next;
			if (head_free & tail_v_reg)
				head_reg <= tail_reg;
			else if (to_head)
				head_reg <= rd_item;
			if (to_tail)
				tail_reg <= rd_item;
		end
	end

	// ----------------------------------------------------------------
	// Bus outputs
	// ----------------------------------------------------------------
	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = head_v_reg;
	assign s_axi_rdata   = head_reg.data;
	assign s_axi_rresp   = head_reg.resp;

endmodule

`default_nettype wire

// ==== verification/ufs_shadow_ctrl_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module ufs_shadow_ctrl_chk
	import ufs_pkg::*;
#(
	parameter int QUEUE_DEPTH = 16
)
(
	input wire logic                         sys_clk,
	input wire logic                         reset,
	input wire logic                         s_axi_awvalid,
	input wire logic                         s_axi_awready,
	input wire logic                         s_axi_wvalid,
	input wire logic                         s_axi_wready,
	input wire logic [1:0]                   s_axi_bresp,
	input wire logic                         s_axi_bvalid,
	input wire logic                         s_axi_bready,
	input wire logic [31:0]                  s_axi_rdata,
	input wire logic                         s_axi_rvalid,
	input wire logic                         s_axi_rready,
	input wire logic [$clog2(QUEUE_DEPTH):0] rx_level,
	input wire logic [$clog2(QUEUE_DEPTH):0] tx_level,
	input wire logic                         tx_empty_prog,
	input wire logic                         queue_enable,
	input wire logic                         receive_queue_reset,
	input wire logic                         transmit_queue_reset,
	input wire logic                         rx_data_avail_irq,
	input wire logic                         tx_holding_empty_irq,
	input wire logic                         rx_dma_req_n,
	input wire logic                         tx_dma_req_n,
	input wire logic                         transmit_halt
);
	// Outputs lag a cycle; skip the edges right after reset
	logic [1:0] age_reg;
	wire        live;
	assign live = (age_reg == 2'h3);
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			age_reg <= 2'h0;
		else if (!live)
			age_reg <= age_reg + 2'h1;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	wire quiet;
	assign quiet = live && !queue_enable;
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_b_due;
		##[1:2] s_axi_bvalid;
	endsequence
	property p_en_fall;
		$fell(queue_enable) |-> receive_queue_reset && transmit_queue_reset;
	endproperty
	property p_halt_gate;
		live && transmit_halt |-> queue_enable || $past(queue_enable);
	endproperty
	property p_rx_off;
		quiet && $past(quiet) |-> rx_data_avail_irq == ($past(rx_level) != 0);
	endproperty
	property p_dma_off;
		quiet && $past(quiet) |-> rx_dma_req_n == ($past(rx_level) == 0)
			&& tx_dma_req_n == ($past(tx_level) != 0);
	endproperty
	property p_tx_plain;
		live && $past(!tx_empty_prog)
			|-> tx_holding_empty_irq == ($past(tx_level) == 0);
	endproperty
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_b_excl;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	property p_wr_answer;
		s_wr_take |-> s_b_due;
	endproperty
	a_en_fall: assert property (p_en_fall)
		else $error("queue reset missing on enable fall");
	a_halt_gate: assert property (p_halt_gate)
		else $error("halt active with queues disabled");
	a_rx_off: assert property (p_rx_off)
		else $error("rx irq wrong with queues disabled");
	a_dma_off: assert property (p_dma_off)
		else $error("dma request wrong in plain mode");
	a_tx_plain: assert property (p_tx_plain)
		else $error("tx irq not tx empty");
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped");
	a_r_hold: assert property (p_r_hold)
		else $error("read response dropped");
	a_b_excl: assert property (p_b_excl)
		else $error("ready while response pending");
	a_wr_answer: assert property (p_wr_answer)
		else $error("write response late");
endmodule
`default_nettype wire

// ==== verification/ufs_queue_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ufs_queue_model
#(
	parameter int QUEUE_DEPTH = 16
)
(
	input  wire logic                         sys_clk,
	input  wire logic                         reset,
	input  wire logic                         q_load,
	input  wire logic [$clog2(QUEUE_DEPTH):0] rx_fill,
	input  wire logic [$clog2(QUEUE_DEPTH):0] tx_fill,
	input  wire logic                         receive_queue_reset,
	input  wire logic                         transmit_queue_reset,
	input  wire logic                         transmit_halt,
	output var  logic [$clog2(QUEUE_DEPTH):0] rx_level,
	output var  logic [$clog2(QUEUE_DEPTH):0] tx_level
);
	localparam int LW = $clog2(QUEUE_DEPTH) + 1;
	// Transmitter sends one character a cycle unless halted
	always_ff @(posedge sys_clk)
	begin
		if (reset || receive_queue_reset)
			rx_level <= '0;
		else if (q_load)
			rx_level <= rx_fill;
		if (reset || transmit_queue_reset)
			tx_level <= '0;
		else if (q_load)
			tx_level <= tx_fill;
		else if (!transmit_halt && tx_level != '0)
			tx_level <= tx_level - LW'(1);
	end
endmodule
`default_nettype wire

// ==== verification/ufs_shadow_ctrl_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	n_mismatch++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module ufs_shadow_ctrl_tb_top
	import ufs_pkg::*;
;
	localparam int QD = 8;
	localparam int LW = $clog2(QD) + 1;
	logic          sys_clk, reset, tx_empty_prog, q_load;
	logic [31:0]   s_axi_awaddr, s_axi_wdata, s_axi_araddr;
	logic          s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic          s_axi_arvalid, s_axi_rready;
	logic [LW-1:0] rx_fill, tx_fill;
	wire  [LW-1:0] rx_level, tx_level;
	wire  [31:0]   s_axi_rdata;
	wire  [1:0]    s_axi_bresp, s_axi_rresp;
	wire           s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire           s_axi_arready, s_axi_rvalid, queue_enable;
	wire           receive_queue_reset, transmit_queue_reset;
	wire           rx_data_avail_irq, tx_holding_empty_irq;
	wire           rx_dma_req_n, tx_dma_req_n, transmit_halt;
	int            n_mismatch, samples_checked, pulses;
	ufs_shadow_ctrl #(.QUEUE_DEPTH(QD)) u_dut (.sys_clk, .reset,
		.s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_level, .tx_level,
		.tx_empty_prog, .queue_enable, .receive_queue_reset,
		.transmit_queue_reset, .rx_data_avail_irq, .tx_holding_empty_irq,
		.rx_dma_req_n, .tx_dma_req_n, .transmit_halt);
	ufs_queue_model #(.QUEUE_DEPTH(QD)) u_queue (.sys_clk, .reset, .q_load,
		.rx_fill, .tx_fill, .receive_queue_reset, .transmit_queue_reset,
		.transmit_halt, .rx_level, .tx_level);
	initial
	begin
		sys_clk = 1'h0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
		if (receive_queue_reset && transmit_queue_reset)
			pulses++;
	function automatic int rx_thr(int t);
		return (t == 0) ? 1 : (t == 3) ? QD - 2 : QD / 2;
	endfunction
	function automatic int tx_thr(int t);
		return (t == 0) ? 0 : (t == 1) ? 2 : QD / 2;
	endfunction
	task automatic final_report();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Bus waits give up after 40 cycles
	task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
		int i;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (i = 0; i < 40 && !s_axi_bvalid; i++)
		begin
			@(posedge sys_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end
		if (!s_axi_bvalid)
		begin
			`CHK("bvalid", 1'h1, s_axi_bvalid)
			final_report();
		end
		s_axi_bready <= 1'h0;
		`CHK("bresp", er, s_axi_bresp)
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [31:0] a, e, input logic [1:0] er);
		int i;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (i = 0; i < 40 && !s_axi_rvalid; i++)
		begin
			@(posedge sys_clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end
		if (!s_axi_rvalid)
		begin
			`CHK("rvalid", 1'h1, s_axi_rvalid)
			final_report();
		end
		s_axi_rready <= 1'h0;
		`CHK("rresp", er, s_axi_rresp)
		`CHK("rdata", e, s_axi_rdata)
		@(posedge sys_clk);
	endtask
	task automatic chk3(input logic e, input logic [1:0] r, s);
		rd(UFS_SFE_ADDR, {31'h0, e}, UFS_RESP_OKAY);
		rd(UFS_SRT_ADDR, {30'h0, r}, UFS_RESP_OKAY);
		rd(UFS_STET_ADDR, {30'h0, s}, UFS_RESP_OKAY);
		`CHK("queue_enable", e, queue_enable)
	endtask
	task automatic set_lv(input int r, s);
		rx_fill <= LW'(r);
		tx_fill <= LW'(s);
		q_load <= 1'h1;
		@(posedge sys_clk);
		q_load <= 1'h0;
		repeat (3) @(posedge sys_clk);
	endtask
	initial
	begin
		int k, t, j, r, s, e;
		logic [7:0] w;
		{reset, tx_empty_prog, q_load, rx_fill, tx_fill} = '0;
		reset = 1'h1;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		k = $urandom(72778);
		repeat (16) @(posedge sys_clk);
		reset <= 1'h0;
		repeat (2) @(posedge sys_clk);
		chk3(1'h0, 2'h0, 2'h0);
		rd(UFS_HALT_ADDR, 32'h0, UFS_RESP_OKAY);
		wr(UFS_PARM_ADDR, $urandom, UFS_RESP_OKAY);
		rd(UFS_PARM_ADDR, 32'h0, UFS_RESP_OKAY);
		wr(32'h500011fc, $urandom, UFS_RESP_DEC);
		rd(32'h500011fc, 32'h0, UFS_RESP_DEC);
		for (k = 0; k < 10; k++)
		begin
			w = 8'($urandom);
			r = $urandom_range(0, 3);
			s = $urandom_range(0, 3);
			e = $urandom_range(0, 1);
			wr(UFS_QCW_ADDR, {24'h0, w & 8'hf9}, UFS_RESP_OKAY);
			chk3(w[0], w[7:6], w[5:4]);
			wr(UFS_SRT_ADDR, 32'(r), UFS_RESP_OKAY);
			chk3(w[0], 2'(r), w[5:4]);
			wr(UFS_STET_ADDR, 32'(s), UFS_RESP_OKAY);
			chk3(w[0], 2'(r), 2'(s));
			wr(UFS_SFE_ADDR, 32'(e), UFS_RESP_OKAY);
			chk3(1'(e), 2'(r), 2'(s));
		end
		wr(UFS_SFE_ADDR, 32'h1, UFS_RESP_OKAY);
		set_lv(5, 0);
		pulses = 0;
		wr(UFS_SFE_ADDR, 32'h1, UFS_RESP_OKAY);
		wr(UFS_SFE_ADDR, 32'h0, UFS_RESP_OKAY);
		`CHK("queue_reset_pulses", 1, pulses)
		`CHK("rx_level", LW'(0), rx_level)
		tx_empty_prog <= 1'h1;
		wr(UFS_HALT_ADDR, 32'h1, UFS_RESP_OKAY);
		for (t = 0; t < 4; t++)
		begin
			wr(UFS_QCW_ADDR, {24'h0, 2'(t), 2'(t), 4'h9}, UFS_RESP_OKAY);
			`CHK("transmit_halt", 1'h1, transmit_halt)
			for (j = 0; j < 3; j++)
			begin
				r = (j == 2) ? $urandom_range(0, QD) : rx_thr(t) - 1 + j;
				s = (j == 2) ? $urandom_range(0, QD) : tx_thr(t) + j;
				set_lv(r, s);
				`CHK("rx_irq", 1'(r >= rx_thr(t)), rx_data_avail_irq)
				`CHK("rx_dma_n", 1'(r < rx_thr(t)), rx_dma_req_n)
				`CHK("tx_irq", 1'(s <= tx_thr(t)), tx_holding_empty_irq)
				`CHK("tx_dma_n", 1'(s > tx_thr(t)), tx_dma_req_n)
				`CHK("tx_hold", LW'(s), tx_level)
			end
		end
		wr(UFS_QCW_ADDR, 32'hf1, UFS_RESP_OKAY);
		set_lv(2, 3);
		`CHK("rx_dma_n", 1'h0, rx_dma_req_n)
		`CHK("tx_dma_n", 1'h1, tx_dma_req_n)
		`CHK("rx_irq", 1'(2 >= rx_thr(3)), rx_data_avail_irq)
		`CHK("tx_irq", 1'(3 <= tx_thr(3)), tx_holding_empty_irq)
		wr(UFS_SFE_ADDR, 32'h0, UFS_RESP_OKAY);
		set_lv(0, 5);
		repeat (8) @(posedge sys_clk);
		`CHK("transmit_halt", 1'h0, transmit_halt)
		`CHK("tx_drain", LW'(0), tx_level)
		wr(UFS_SFE_ADDR, 32'h1, UFS_RESP_OKAY);
		wr(UFS_HALT_ADDR, 32'h0, UFS_RESP_OKAY);
		set_lv(0, 5);
		repeat (8) @(posedge sys_clk);
		`CHK("tx_drain", LW'(0), tx_level)
		final_report();
	end
endmodule
bind ufs_shadow_ctrl ufs_shadow_ctrl_chk #(.QUEUE_DEPTH(QUEUE_DEPTH)) u_chk (
	.sys_clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .rx_level, .tx_level, .tx_empty_prog,
	.queue_enable, .receive_queue_reset, .transmit_queue_reset,
	.rx_data_avail_irq, .tx_holding_empty_irq, .rx_dma_req_n, .tx_dma_req_n,
	.transmit_halt);
`default_nettype wire
